// File: npr_array_model.sv
// behavioural model of the two nonvolatile arrays behind the read port
`timescale 1ns/1ps
`default_nettype none

module npr_array_model (
    input wire logic i_mem_rd,
    input wire logic i_mem_array,
    input wire logic [13:0] i_mem_page,
    input wire logic [3:0] i_mem_byte,
    output logic [7:0] o_mem_data
);
    // ------------------------------------------------------------------
    // read data, valid while the strobe stands
    // ------------------------------------------------------------------
    // the engine launches the address with the strobe and pushes the
    // byte at the end of that cycle, so the array answers within it
    // pattern: low page bits and byte index, user array xor a5
    wire [7:0] pattern = {i_mem_page[3:0], i_mem_byte}
        ^ (i_mem_array ? 8'hA5 : 8'h00);
    // without a strobe the line shows the inverse, so a stray sample fails
    assign o_mem_data = i_mem_rd ? pattern : ~pattern;
endmodule
`default_nettype wire

// File: npr_fifo.sv
// constants package and output byte fifo for the nonvolatile page read-out
`timescale 1ns/1ps
`default_nettype none

package npr_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_RETR_LARGE_NS = 240;
    localparam int T_RETR_SMALL_NS = 360;
    // least times round up to whole cycles
    localparam logic [3:0] RETR_LARGE_CYC =
        4'((T_RETR_LARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RETR_SMALL_CYC =
        4'((T_RETR_SMALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ------------------------------------------------------------------
    // command framing
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_CFG_DEF = 8'h73;
    localparam logic [7:0] CMD_READ_USER_DEF = 8'hCA;
    localparam logic [1:0] OPERAND_LAST = 2'h2;
    localparam int PAGE_COUNT_W = 14;
    localparam logic [13:0] PAGE_COUNT_MAX = 14'h3FFF;
    // ------------------------------------------------------------------
    // page layout and filler
    // ------------------------------------------------------------------
    localparam int PAGE_BYTES_DEF = 16;
    localparam int PAGE_ADDR_W_DEF = 14;
    localparam int FIFO_DEPTH_DEF = 32;
    localparam logic [4:0] I2C_GAP_BYTES = 5'h10;
    localparam logic [4:0] I2C_DUMMY_BYTES = 5'h04;
    localparam logic [7:0] FILL_BYTE = 8'h00;
endpackage

module npr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = npr_pkg::FIFO_DEPTH_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;

    wire do_wr = i_in_valid && o_in_ready;
    // output stage refills from a non-empty fifo whenever it is empty or being drained
    wire do_ld = (fill != '0) && (!o_out_valid || i_out_ready);
    wire [AW:0] fill_up = fill + (AW+1)'(do_wr);

    assign o_in_ready = fill != (AW+1)'(DEPTH);

    always_ff @(posedge i_clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else if (i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(do_wr);
            rd_ptr <= rd_ptr + AW'(do_ld);
            fill <= fill_up - (AW+1)'(do_ld);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else if (i_flush) begin
            o_out_valid <= 1'b0;
        end else if (do_ld) begin
            o_out_valid <= 1'b1;
            o_out_data <= mem[rd_ptr];
        end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// File: npr_page_readout.sv
// page read-out engine for the config and user nonvolatile arrays
`timescale 1ns/1ps
`default_nettype none

module npr_page_readout #(
    parameter logic [7:0] CMD_READ_CFG = npr_pkg::CMD_READ_CFG_DEF,
    parameter logic [7:0] CMD_READ_USER = npr_pkg::CMD_READ_USER_DEF,
    parameter bit SMALL_DENSITY = 1'b0,
    parameter int PAGE_BYTES = npr_pkg::PAGE_BYTES_DEF,
    parameter int PAGE_ADDR_W = npr_pkg::PAGE_ADDR_W_DEF,
    parameter int FIFO_DEPTH = npr_pkg::FIFO_DEPTH_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end,
    input wire logic i_port_is_i2c,
    input wire logic [PAGE_ADDR_W-1:0] i_page_ptr,
    output logic o_mem_rd,
    output logic o_mem_array,
    output logic [PAGE_ADDR_W-1:0] o_mem_page,
    output logic [$clog2(PAGE_BYTES)-1:0] o_mem_byte,
    input wire logic [7:0] i_mem_data,
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    input wire logic i_tx_ready,
    output logic o_busy
);
    localparam int BW = $clog2(PAGE_BYTES);
    localparam int CW = npr_pkg::PAGE_COUNT_W;
    localparam logic [3:0] RETR_CYC = SMALL_DENSITY ?
        npr_pkg::RETR_SMALL_CYC : npr_pkg::RETR_LARGE_CYC;

    typedef enum logic [2:0] {
        S_IDLE, S_OPER, S_WAIT, S_PAGE, S_FILL
    } npr_state_t;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    npr_state_t state, next_state;
    logic array_sel;
    logic is_i2c;
    logic [1:0] op_cnt;
    logic [CW-1:0] count;
    logic [3:0] wait_cnt;
    logic [PAGE_ADDR_W-1:0] page, next_page;
    logic [BW-1:0] byte_idx;
    logic rd_pending;
    logic [CW-1:0] emitted;
    logic [4:0] fill_cnt, next_fill_cnt;
    logic fill_last, next_fill_last;
    logic fifo_in_ready;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire is_cfg_cmd = i_rx_byte == CMD_READ_CFG;
    wire is_user_cmd = i_rx_byte == CMD_READ_USER;
    wire rx_cmd = i_rx_valid && (is_cfg_cmd || is_user_cmd);
    wire cmd_take = state == S_IDLE && rx_cmd && !i_rx_end;
    wire op_take = state == S_OPER && i_rx_valid;
    wire issue = state == S_PAGE && !rd_pending && fifo_in_ready;
    wire push_mem = state == S_PAGE && rd_pending;
    wire last_byte = byte_idx == BW'(PAGE_BYTES - 1);
    wire page_end = push_mem && last_byte;
    // a zero count is read as a single page
    wire [CW-1:0] eff_count = (count == '0) ? CW'(1) : count;
    wire [CW-1:0] next_emitted = emitted + CW'(1);
    wire more = next_emitted < eff_count;
    wire first_page = emitted == '0;
    wire push_fill = state == S_FILL && fifo_in_ready;
    wire fill_end = push_fill && fill_cnt == 5'h01;
    wire fifo_in_valid = push_mem || push_fill;
    wire [7:0] fifo_in_data = push_mem ? i_mem_data : npr_pkg::FILL_BYTE;

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_page = page;
        next_fill_cnt = fill_cnt;
        next_fill_last = fill_last;
        if (i_rx_end) begin
            next_state = S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (rx_cmd) begin
                        next_state = S_OPER;
                    end
                end
                S_OPER: begin
                    if (i_rx_valid && op_cnt == npr_pkg::OPERAND_LAST) begin
                        next_state = S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (wait_cnt == 4'h0) begin
                        next_state = S_PAGE;
                        next_page = i_page_ptr;
                    end
                end
                S_PAGE: begin
                    if (page_end && !more) begin
                        next_state = S_IDLE;
                        if (is_i2c && !first_page) begin
                            next_state = S_FILL;
                            next_fill_cnt = npr_pkg::I2C_DUMMY_BYTES;
                            next_fill_last = 1'b1;
                        end
                    end else if (page_end && first_page) begin
                        // page stays put: the pointer page goes out twice
                        if (is_i2c) begin
                            next_state = S_FILL;
                            next_fill_cnt = npr_pkg::I2C_GAP_BYTES;
                            next_fill_last = 1'b0;
                        end
                    end else if (page_end) begin
                        next_page = page + PAGE_ADDR_W'(1);
                        if (is_i2c) begin
                            next_state = S_FILL;
                            next_fill_cnt = npr_pkg::I2C_DUMMY_BYTES;
                            next_fill_last = 1'b0;
                        end
                    end
                end
                S_FILL: begin
                    if (fill_end) begin
                        next_state = fill_last ? S_IDLE : S_PAGE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= S_IDLE;
            page <= '0;
            fill_cnt <= '0;
            fill_last <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            state <= next_state;
            page <= next_page;
            fill_cnt <= push_fill ? fill_cnt - 5'h01 : next_fill_cnt;
            fill_last <= next_fill_last;
            o_busy <= next_state != S_IDLE;
        end
    end

    // the retrieval delay runs under the operand bytes, so a slow port
    // sees only the single cycle spent in S_WAIT after the last operand
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_cnt <= 4'h0;
            op_cnt <= 2'h0;
            count <= '0;
            array_sel <= 1'b0;
            is_i2c <= 1'b0;
        end else if (cmd_take) begin
            wait_cnt <= RETR_CYC;
            op_cnt <= 2'h0;
            array_sel <= is_user_cmd;
            is_i2c <= i_port_is_i2c;
        end else begin
            if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
            if (op_take) begin
                // last two operand bytes carry the page count
                op_cnt <= op_cnt + 2'h1;
                count <= CW'({count[5:0], i_rx_byte});
            end
        end
    end

    // one read in flight at a time; room was checked when it was issued
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_pending <= 1'b0;
            byte_idx <= '0;
            emitted <= '0;
            o_mem_rd <= 1'b0;
            o_mem_array <= 1'b0;
            o_mem_page <= '0;
            o_mem_byte <= '0;
        end else begin
            rd_pending <= issue;
            o_mem_rd <= issue;
            if (state == S_WAIT) begin
                byte_idx <= '0;
                emitted <= '0;
            end else if (push_mem) begin
                byte_idx <= last_byte ? '0 : byte_idx + BW'(1);
                if (last_byte) begin
                    emitted <= next_emitted;
                end
            end
            if (issue) begin
                o_mem_array <= array_sel;
                o_mem_page <= page;
                o_mem_byte <= byte_idx;
            end
        end
    end

    // ------------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------------
    npr_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_flush(i_rx_end),
        .i_in_valid(fifo_in_valid),
        .i_in_data(fifo_in_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(o_tx_valid),
        .o_out_data(o_tx_byte),
        .i_out_ready(i_tx_ready)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    sequence cmd_accept_s;
        state == S_IDLE && i_rx_valid && is_user_cmd && !i_rx_end;
    endsequence

    sequence first_dup_end_s;
        page_end && first_page && more && !i_rx_end;
    endsequence

    user_select_a: assert property (
        cmd_accept_s |=> state == S_OPER && array_sel)
        else $error("user array command not latched");

    fetch_start_a: assert property (
        cmd_accept_s |=> wait_cnt == RETR_CYC ##1 wait_cnt == RETR_CYC - 4'h1)
        else $error("retrieval count did not start on command");

    first_page_a: assert property (
        state == S_WAIT && wait_cnt == 4'h0 && !i_rx_end
        |=> state == S_PAGE && page == $past(i_page_ptr))
        else $error("first page is not the pointer page");

    dup_page_a: assert property (
        first_dup_end_s |=> page == $past(page))
        else $error("pointer page not repeated");

    ascend_page_a: assert property (
        page_end && !first_page && more && !i_rx_end
        |=> page == $past(page) + PAGE_ADDR_W'(1))
        else $error("page address did not step up");

    i2c_gap_a: assert property (
        first_dup_end_s and is_i2c
        |=> state == S_FILL && fill_cnt == npr_pkg::I2C_GAP_BYTES)
        else $error("sixteen byte gap missing");

    i2c_dummy_a: assert property (
        page_end && !first_page && is_i2c && !i_rx_end
        |=> state == S_FILL && fill_cnt == npr_pkg::I2C_DUMMY_BYTES)
        else $error("four dummy bytes missing");

    spi_no_fill_a: assert property (
        state == S_FILL |-> is_i2c)
        else $error("filler bytes on a non-I2C port");

    abort_clean_a: assert property (
        i_rx_end |=> state == S_IDLE && !o_tx_valid ##1 !o_tx_valid)
        else $error("read not dropped after host stop");

    single_page_a: assert property (
        page_end && !more && !is_i2c && !i_rx_end |=> state == S_IDLE)
        else $error("single page read did not finish");
endmodule

`default_nettype wire

// File: testbench.sv
// self-checking bench for the nonvolatile page read-out engine
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ------------------------------------------------------------------
    // clock, stimulus and wiring
    // ------------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_end = 1'b0;
    logic port_is_i2c = 1'b0;
    logic [13:0] page_ptr = 14'h0000;
    logic tx_ready = 1'b1;
    logic mem_rd;
    logic mem_array;
    logic tx_valid;
    logic busy;
    logic [13:0] mem_page;
    logic [3:0] mem_byte;
    logic [7:0] mem_data;
    logic [7:0] tx_byte;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int t_cmd = 0;
    int first_rd = -1;
    int rd_count = 0;
    int op_gap = 0;

    always #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (mem_rd === 1'b1) begin
            rd_count <= rd_count + 1;
            if (first_rd < 0) begin
                first_rd <= cyc;
            end
        end
    end

    npr_page_readout dut_u (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_rx_valid(rx_valid),
        .i_rx_byte(rx_byte), .i_rx_end(rx_end),
        .i_port_is_i2c(port_is_i2c), .i_page_ptr(page_ptr),
        .o_mem_rd(mem_rd), .o_mem_array(mem_array), .o_mem_page(mem_page),
        .o_mem_byte(mem_byte), .i_mem_data(mem_data),
        .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
        .i_tx_ready(tx_ready), .o_busy(busy)
    );

    npr_array_model mem_u (
        .i_mem_rd(mem_rd), .i_mem_array(mem_array),
        .i_mem_page(mem_page), .i_mem_byte(mem_byte), .o_mem_data(mem_data)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] pat(logic arr, logic [13:0] pg,
                                       logic [3:0] bi);
        return {pg[3:0], bi} ^ (arr ? 8'hA5 : 8'h00);
    endfunction

    // command then three operands, back to back unless op_gap spaces the first; count in the low 14 bits
    task automatic send_req(input logic [7:0] cmd, input logic [13:0] cnt);
        logic [7:0] b [4];
        b = '{cmd, 8'h00, {2'b00, cnt[13:8]}, cnt[7:0]};
        first_rd = -1;
        rd_count = 0;
        for (int i = 0; i < 4; i++) begin
            rx_valid <= 1'b1;
            rx_byte <= b[i];
            @(posedge clk_sys);
            if (i == 0) t_cmd = cyc;
            // a slow host spaces the first operand past the retrieval time
            if (i == 0 && op_gap > 0) begin
                rx_valid <= 1'b0;
                repeat (op_gap) @(posedge clk_sys);
            end
        end
        rx_valid <= 1'b0;
    endtask

    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 400);
        b = tx_byte;
        if (n >= 400) check(32'h0, 32'h1);
    endtask

    task automatic expect_page(input logic arr, input logic [13:0] pg);
        logic [7:0] b;
        for (int i = 0; i < 16; i++) begin
            get_byte(b);
            check(b, pat(arr, pg, i[3:0]));
        end
    endtask

    task automatic expect_fill(input int n);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            get_byte(b);
            check(b, npr_pkg::FILL_BYTE);
        end
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (busy !== 1'b0 && n < 300);
        check(busy, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic scen_single;
        page_ptr <= 14'h0007;
        rx_valid <= 1'b1;
        rx_byte <= 8'h11;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        check(busy, 1'b0);
        send_req(npr_pkg::CMD_READ_CFG_DEF, 14'h0001);
        expect_page(1'b0, 14'h0007);
        check(mem_array, 1'b0);
        check(first_rd - t_cmd >= int'(npr_pkg::RETR_LARGE_CYC), 1);
        // host ends the transfer right after the last byte of the page
        rx_end <= 1'b1;
        @(posedge clk_sys);
        rx_end <= 1'b0;
        wait_idle();
        check(tx_valid, 1'b0);
    endtask

    task automatic scen_multi;
        page_ptr <= 14'h0005;
        op_gap = int'(npr_pkg::RETR_LARGE_CYC);
        send_req(npr_pkg::CMD_READ_USER_DEF, 14'h0003);
        op_gap = 0;
        expect_page(1'b1, 14'h0005);
        expect_page(1'b1, 14'h0005);
        expect_page(1'b1, 14'h0006);
        check(mem_array, 1'b1);
        wait_idle();
        check(tx_valid, 1'b0);
    endtask

    task automatic scen_i2c;
        port_is_i2c <= 1'b1;
        page_ptr <= 14'h0009;
        send_req(npr_pkg::CMD_READ_CFG_DEF, 14'h0003);
        expect_page(1'b0, 14'h0009);
        expect_fill(16);
        expect_page(1'b0, 14'h0009);
        expect_fill(4);
        expect_page(1'b0, 14'h000A);
        expect_fill(4);
        wait_idle();
        send_req(npr_pkg::CMD_READ_USER_DEF, 14'h0001);
        expect_page(1'b1, 14'h0009);
        wait_idle();
        check(tx_valid, 1'b0);
        port_is_i2c <= 1'b0;
    endtask

    task automatic scen_abort;
        page_ptr <= 14'h0002;
        send_req(npr_pkg::CMD_READ_USER_DEF, npr_pkg::PAGE_COUNT_MAX);
        expect_page(1'b1, 14'h0002);
        expect_page(1'b1, 14'h0002);
        expect_page(1'b1, 14'h0003);
        expect_page(1'b1, 14'h0004);
        rx_end <= 1'b1;
        @(posedge clk_sys);
        rx_end <= 1'b0;
        @(posedge clk_sys);
        check(tx_valid, 1'b0);
        check(busy, 1'b0);
        repeat (20) @(posedge clk_sys);
        check(tx_valid, 1'b0);
        send_req(npr_pkg::CMD_READ_CFG_DEF, 14'h0001);
        expect_page(1'b0, 14'h0002);
        wait_idle();
    endtask

    // the far side stalls: the fifo plus its output stage fill, then drain
    task automatic scen_stall;
        tx_ready <= 1'b0;
        page_ptr <= 14'h000B;
        send_req(npr_pkg::CMD_READ_USER_DEF, 14'h0004);
        repeat (150) @(posedge clk_sys);
        check(rd_count, 33);
        check(tx_valid, 1'b1);
        tx_ready <= 1'b1;
        expect_page(1'b1, 14'h000B);
        expect_page(1'b1, 14'h000B);
        expect_page(1'b1, 14'h000C);
        expect_page(1'b1, 14'h000D);
        wait_idle();
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        check(busy, 1'b0);
        scen_single();
        scen_multi();
        scen_i2c();
        scen_abort();
        scen_stall();
        summarize();
    end

    // all scenarios need under two thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
